/* File: fcl_regs.svh */
// Register offsets, field positions and codes of the fuse configuration loader.
`ifndef FCL_REGS_SVH
`define FCL_REGS_SVH
// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define FCL_A_STATUS 12'h000
`define FCL_A_CTRL 12'h004
`define FCL_A_PADDR 12'h008
`define FCL_A_PDATA 12'h00c
`define FCL_A_INVAL 12'h010
`define FCL_A_ID 12'h014
// ----------------------------------------------------------------------
// Register fields
// ----------------------------------------------------------------------
`define FCL_C_RESTART 0
`define FCL_C_CLRREF 1
`define FCL_S_BUSY 0
`define FCL_S_DONE 1
`define FCL_S_LOCK 2
`define FCL_S_REFUSED 3
`define FCL_S_VER 12:8
`define FCL_S_CNT 22:16
`define FCL_PADDR_F 5:0
// Identification value; arbitrary, it names no real part.
`define FCL_DEV_ID_DEF 32'h0000_5a5a
// ----------------------------------------------------------------------
// Store geometry
// ----------------------------------------------------------------------
`define FCL_LINES 32
`define FCL_LAST_LOC 6'h3f
`define FCL_FIRST_ID_LOC 6'h3d
`define FCL_HI_HALF 63:32
`define FCL_LO_HALF 31:0
// ----------------------------------------------------------------------
// Entry fields and codes
// ----------------------------------------------------------------------
`define FCL_TYPE 2:0
`define FCL_RTYPE 4:3
`define FCL_RSV 8:5
`define FCL_WADDR 15:9
`define FCL_PHY_ADDR 15:11
`define FCL_HI 31:16
`define FCL_LO 15:0
`define FCL_T_BLANK 3'h0
`define FCL_T_WORD 3'h1
`define FCL_T_CSR 3'h2
`define FCL_T_PHY 3'h3
`define FCL_T_INVAL 3'h7
`define FCL_RT_POWER 2'h0
`define FCL_RT_RSV 2'h1
`define FCL_RT_PCIE 2'h2
`define FCL_RT_ALL 2'h3
`define FCL_VER_RT 2'h1
`define FCL_VER_RSV 4'hf
`define FCL_INVAL_SET 32'h0000_0007
`define FCL_W_MAC_LO 7'h00
`define FCL_W_MAC_MID 7'h01
`define FCL_W_MAC_HI 7'h02
`define FCL_W_INIT1 7'h0a
`define FCL_LOCK_BIT 15
`define FCL_GPAR_BIT 0
`define FCL_PHY_PM_ADDR 5'h10
`define FCL_DISC_BIT 5
`endif

/* File: fcl_pkg.sv */
// Types shared by the fuse configuration loader.
package fcl_pkg;
	typedef enum {S_IDLE, S_RD, S_DEC, S_RD2, S_CSR, S_PRD, S_PWR} fcl_state_e;
	typedef enum logic [1:0] {CAUSE_POWER, CAUSE_PCIE, CAUSE_SW} fcl_cause_e;
endpackage

/* File: fcl_store.sv */
// Fuse array of 64-bit lines, read and written one 32-bit location at a time.
`timescale 1ns/1ps
`include "fcl_regs.svh"
module fcl_store #(
	parameter int LINES = `FCL_LINES,
	parameter int AW = 6
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [AW-1:0] raddr,
	output logic [31:0] rdata,
	input wire logic we,
	input wire logic [AW-1:0] waddr,
	input wire logic [31:0] wdata
);
	logic [63:0] mem [LINES];

	// Unburnt fuses read as zero.
	initial
	begin
		for (int i = 0; i < LINES; i++)
			mem[i] = '0;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			rdata <= '0;
		else if (raddr[0])
			rdata <= mem[raddr[AW-1:1]][`FCL_HI_HALF];
		else
			rdata <= mem[raddr[AW-1:1]][`FCL_LO_HALF];
	end

	// A plain always, since the array may also be preloaded from outside.
	always @(posedge pclk)
	begin
		if (we && waddr[0])
			mem[waddr[AW-1:1]][`FCL_HI_HALF] <= wdata;
		else if (we)
			mem[waddr[AW-1:1]][`FCL_LO_HALF] <= wdata;
	end
endmodule

/* File: fcl_parser.sv */
// Fuse configuration store walker with APB access and programming gate.
// How it works
// [R01] The store holds 64 thirty-two-bit locations, room for 32 two-location CSR entries.
// [R02] A programmed location is rewritten only to invalidate it; new data goes to blank ones.
// [R03] Locations 61 to 63 hold identity and version and never load anything.
// [R04] Word entries take 2 words, CSR entries 4 words, PHY entries 2 words.
// [R05] An unknown non-zero type skips its 32-bit location and walking goes on.
// [R06] Type 111b locations are skipped one after another until another type.
// [R07] Whoever invalidates an entry sets all three type bits to one.
// [R08] Type 000b marks a blank location and ends the walk.
// [R09] Codes: 001b word, 010b CSR, 011b PHY; 100b is reserved.
// [R10] Any other reserved type is skipped like an unknown one.
// [R11] Reset type 00b power-good only, 10b PCIe too, 11b also software.
// [R12] The programmer writes the reset type that matches the intended loads.
// [R13] Word entry: type 2:0, reset type 4:3, address 15:9, data high half.
// [R14] Word addresses 0x00, 0x01, 0x02 load the station address parts.
// [R15] Word 0x0A with bit 15 set locks programming while the strap is on.
// [R16] With the strap off, blank locations can be programmed again.
// [R17] The board turns the security strap back on after reprogramming.
// [R18] Version entry: invalid type, 01b and 1111b, ones count in 31:16.
// [R19] A PHY entry to power management bit 5 keeps the link disconnected.
// [R20] Every reset starts a walk; entries load only when reset type matches.
// [R21] The store is built as 32 lines of 64 bits.
// [R22] The walk also ends after the last location.
// [R23] PHY entries load phy_addr and phy_data only on a match; csr_addr and csr_data take every CSR entry, matching or not.
`timescale 1ns/1ps
`include "fcl_regs.svh"
module fcl_parser
	import fcl_pkg::*;
#(
	parameter logic [31:0] DEV_ID = `FCL_DEV_ID_DEF
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic security_strap,
	input wire logic pcie_reset_done,
	input wire logic sw_reset_done,
	output logic word_we,
	output logic [6:0] word_addr,
	output logic [15:0] word_data,
	output logic csr_we,
	output logic [15:0] csr_addr,
	output logic [31:0] csr_data,
	output logic phy_we,
	output logic [4:0] phy_addr,
	output logic [15:0] phy_data,
	output logic [47:0] station_addr,
	output logic global_parity_enable,
	output logic phy_link_disconnect,
	output logic fuse_lockout,
	output logic walk_busy,
	output logic walk_done
);
	// ------------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------------
	function automatic logic rt_match(input logic [1:0] rt,
		input fcl_cause_e c);
		unique case (rt)
			`FCL_RT_POWER: rt_match = (c == CAUSE_POWER);
			`FCL_RT_PCIE: rt_match = (c != CAUSE_SW);
			`FCL_RT_ALL: rt_match = 1'b1;
			`FCL_RT_RSV: rt_match = 1'b0;
		endcase
	endfunction

	function automatic logic [4:0] ones(input logic [15:0] v);
		logic [4:0] n;
		n = '0;
		for (int i = 0; i < 16; i++)
			n = n + {4'h0, v[i]};
		ones = n;
	endfunction

	fcl_state_e state;
	fcl_cause_e cause, pend_cause;
	logic [5:0] loc, prog_addr, raddr;
	logic [31:0] mem_rdata, mem_wdata, prog_data, csr_hdr, st;
	logic [2:0] sync_a, sync_b, sync_c;
	logic [2:0] typ;
	logic [4:0] version;
	logic [6:0] load_cnt;
	logic mem_we, walk_pend, prog_pend, prog_inval, refused, lock_seen;
	logic csr_ok, hit, at_end, strap_s, ev_pcie, ev_sw, start;
	logic wr, rd_setup, addr_ok, prog_req, prog_ok, sw_restart;

	// ------------------------------------------------------------------
	// Store, 32 lines of 64 bits
	// ------------------------------------------------------------------
	fcl_store u_store ( // [R21] [R01]
		.pclk(pclk),
		.presetn(presetn),
		.raddr(raddr),
		.rdata(mem_rdata),
		.we(mem_we),
		.waddr(prog_addr),
		.wdata(mem_wdata)
	);

	// ------------------------------------------------------------------
	// Pin synchronisers and reset events
	// ------------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			sync_a <= '0;
			sync_b <= '0;
			sync_c <= '0;
		end
		else
		begin
			sync_a <= {sw_reset_done, pcie_reset_done, security_strap};
			sync_b <= sync_a;
			sync_c <= sync_b;
		end
	end

	assign strap_s = sync_b[0];
	assign ev_pcie = sync_b[1] && !sync_c[1];
	assign ev_sw = sync_b[2] && !sync_c[2];

	// ------------------------------------------------------------------
	// Decode of the location just read
	// ------------------------------------------------------------------
	assign typ = mem_rdata[`FCL_TYPE];
	assign at_end = (loc == `FCL_LAST_LOC);
	assign hit = rt_match(mem_rdata[`FCL_RTYPE], cause)
		&& (loc < `FCL_FIRST_ID_LOC); // [R11] [R03] [R20]
	assign raddr = (state == S_PRD) ? prog_addr : loc;
	assign start = (state == S_IDLE) && walk_pend;

	// ------------------------------------------------------------------
	// Walk and programming sequencer
	// ------------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state <= S_IDLE;
			loc <= '0;
			cause <= CAUSE_POWER;
		end
		else
		begin
			unique case (state)
				S_IDLE:
				begin
					if (walk_pend)
					begin
						state <= S_RD; // [R20]
						loc <= '0;
						cause <= pend_cause;
					end
					else if (prog_pend)
						state <= S_PRD;
				end
				S_RD: state <= S_DEC;
				S_DEC:
				begin
					if (typ == `FCL_T_BLANK || at_end)
						state <= S_IDLE; // [R08] [R22]
					else if (typ == `FCL_T_CSR)
					begin
						loc <= loc + 6'h1; // [R04]
						state <= S_RD2;
					end
					else
					begin
						loc <= loc + 6'h1; // [R05] [R06] [R10]
						state <= S_RD;
					end
				end
				S_RD2: state <= S_CSR;
				S_CSR:
				begin
					if (at_end)
						state <= S_IDLE; // [R22]
					else
					begin
						loc <= loc + 6'h1;
						state <= S_RD;
					end
				end
				S_PRD: state <= S_PWR;
				S_PWR: state <= S_IDLE;
			endcase
		end
	end

	// ------------------------------------------------------------------
	// Entry loads
	// ------------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			word_we <= 1'b0;
			word_addr <= '0;
			word_data <= '0;
			phy_we <= 1'b0;
			phy_addr <= '0;
			phy_data <= '0;
		end
		else
		begin
			word_we <= (state == S_DEC) && (typ == `FCL_T_WORD) && hit;
			phy_we <= (state == S_DEC) && (typ == `FCL_T_PHY) && hit;
			if (state == S_DEC && typ == `FCL_T_WORD && hit) // [R09]
			begin
				word_addr <= mem_rdata[`FCL_WADDR]; // [R13]
				word_data <= mem_rdata[`FCL_HI];
			end
			if (state == S_DEC && typ == `FCL_T_PHY && hit) // [R09]
			begin
				phy_addr <= mem_rdata[`FCL_PHY_ADDR]; // [R23]
				phy_data <= mem_rdata[`FCL_HI];
			end
		end
	end

	// The CSR header is held while its data location is fetched.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			csr_hdr <= '0;
			csr_ok <= 1'b0;
			csr_we <= 1'b0;
			csr_addr <= '0;
			csr_data <= '0;
		end
		else
		begin
			if (state == S_DEC)
			begin
				csr_hdr <= mem_rdata;
				csr_ok <= hit;
			end
			csr_we <= (state == S_CSR) && csr_ok
				&& (loc < `FCL_FIRST_ID_LOC); // [R23] [R03]
			if (state == S_CSR)
			begin
				csr_addr <= csr_hdr[`FCL_HI];
				csr_data <= mem_rdata;
			end
		end
	end

	// ------------------------------------------------------------------
	// Internal structures fed by word and PHY loads
	// ------------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			station_addr <= '0;
			global_parity_enable <= 1'b0;
			phy_link_disconnect <= 1'b0;
		end
		else
		begin
			if (word_we && word_addr == `FCL_W_MAC_LO)
				station_addr[15:0] <= word_data; // [R14]
			if (word_we && word_addr == `FCL_W_MAC_MID)
				station_addr[31:16] <= word_data; // [R14]
			if (word_we && word_addr == `FCL_W_MAC_HI)
				station_addr[47:32] <= word_data; // [R14]
			if (word_we && word_addr == `FCL_W_INIT1)
				global_parity_enable <= word_data[`FCL_GPAR_BIT];
			if (phy_we && phy_addr == `FCL_PHY_PM_ADDR)
				phy_link_disconnect <= phy_data[`FCL_DISC_BIT]; // [R19]
		end
	end

	// Lock entry is honoured whatever its reset type; version is kept.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			lock_seen <= 1'b0;
			version <= '0;
			load_cnt <= '0;
			walk_done <= 1'b0;
		end
		else if (start)
		begin
			lock_seen <= 1'b0;
			load_cnt <= '0;
			walk_done <= 1'b0;
		end
		else
		begin
			if (state == S_DEC && typ == `FCL_T_WORD
				&& loc < `FCL_FIRST_ID_LOC
				&& mem_rdata[`FCL_WADDR] == `FCL_W_INIT1
				&& mem_rdata[16 + `FCL_LOCK_BIT])
				lock_seen <= 1'b1; // [R15]
			if (state == S_DEC && typ == `FCL_T_INVAL
				&& mem_rdata[`FCL_RTYPE] == `FCL_VER_RT
				&& mem_rdata[`FCL_RSV] == `FCL_VER_RSV)
				version <= ones(mem_rdata[`FCL_HI]); // [R18]
			if (word_we || phy_we || csr_we)
				load_cnt <= load_cnt + 7'h1;
			if ((state == S_DEC && (typ == `FCL_T_BLANK || at_end))
				|| (state == S_CSR && at_end))
				walk_done <= 1'b1;
		end
	end

	assign fuse_lockout = lock_seen && strap_s; // [R15] [R16]
	assign walk_busy = (state != S_IDLE) || walk_pend;

	// ------------------------------------------------------------------
	// Walk requests; a new reset never gets lost behind a running walk
	// ------------------------------------------------------------------
	assign sw_restart = wr && paddr == `FCL_A_CTRL
		&& pwdata[`FCL_C_RESTART];

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			walk_pend <= 1'b1;
			pend_cause <= CAUSE_POWER;
		end
		else
		begin
			walk_pend <= ev_pcie || ev_sw || sw_restart
				|| (walk_pend && !start); // [R20]
			if (ev_pcie && !(walk_pend && !start
				&& pend_cause == CAUSE_POWER))
				pend_cause <= CAUSE_PCIE;
			else if ((ev_sw || sw_restart) && !(walk_pend && !start))
				pend_cause <= CAUSE_SW;
		end
	end

	// ------------------------------------------------------------------
	// Programming of blank locations and invalidation of programmed ones
	// ------------------------------------------------------------------
	assign prog_req = wr && (paddr == `FCL_A_PDATA
		|| paddr == `FCL_A_INVAL);
	assign prog_ok = !walk_busy && !prog_pend && !fuse_lockout;

	always_comb
	begin
		mem_we = 1'b0;
		mem_wdata = prog_data;
		if (state == S_PWR && prog_inval)
		begin
			mem_we = 1'b1;
			mem_wdata = mem_rdata | `FCL_INVAL_SET; // [R07]
		end
		else if (state == S_PWR)
			mem_we = (mem_rdata == '0); // [R02] [R16]
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			prog_pend <= 1'b0;
			prog_inval <= 1'b0;
			prog_addr <= '0;
			prog_data <= '0;
		end
		else
		begin
			if (prog_req && prog_ok)
			begin
				prog_pend <= 1'b1; // [R15] [R16]
				prog_inval <= (paddr == `FCL_A_INVAL);
			end
			else if (state == S_PRD)
				prog_pend <= 1'b0;
			if (wr && paddr == `FCL_A_PDATA && prog_ok)
				prog_data <= pwdata;
			if (wr && (paddr == `FCL_A_PADDR
				|| paddr == `FCL_A_INVAL) && prog_ok)
				prog_addr <= pwdata[`FCL_PADDR_F];
		end
	end

	// A refusal sets the flag even in the cycle software clears it.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			refused <= 1'b0;
		else if ((prog_req && !prog_ok)
			|| (state == S_PWR && !prog_inval && mem_rdata != '0))
			refused <= 1'b1; // [R02]
		else if (wr && paddr == `FCL_A_CTRL && pwdata[`FCL_C_CLRREF])
			refused <= 1'b0;
	end

	// ------------------------------------------------------------------
	// APB slave
	// ------------------------------------------------------------------
	assign wr = psel && penable && pwrite;
	assign rd_setup = psel && !penable && !pwrite;
	assign addr_ok = paddr == `FCL_A_STATUS || paddr == `FCL_A_CTRL
		|| paddr == `FCL_A_PADDR || paddr == `FCL_A_PDATA
		|| paddr == `FCL_A_INVAL || paddr == `FCL_A_ID;
	assign pready = 1'b1;
	assign pslverr = psel && penable && !addr_ok;

	always_comb
	begin
		st = '0;
		st[`FCL_S_BUSY] = walk_busy;
		st[`FCL_S_DONE] = walk_done;
		st[`FCL_S_LOCK] = fuse_lockout;
		st[`FCL_S_REFUSED] = refused;
		st[`FCL_S_VER] = version;
		st[`FCL_S_CNT] = load_cnt;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			prdata <= '0;
		else if (rd_setup)
		begin
			unique case (paddr)
				`FCL_A_STATUS: prdata <= st;
				`FCL_A_PADDR: prdata <= {26'h0, prog_addr};
				`FCL_A_PDATA: prdata <= prog_data;
				`FCL_A_ID: prdata <= DEV_ID;
				default: prdata <= '0;
			endcase
		end
	end

	// ------------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------------
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	chk_blank_stops: assert property ( // [R08]
		state == S_DEC && typ == `FCL_T_BLANK |=> state == S_IDLE
			&& !word_we && walk_done)
		else $error("walk did not end on a blank location");
	chk_last_ends: assert property ( // [R22]
		state == S_DEC && at_end |=> state == S_IDLE && walk_done
			&& loc == $past(loc))
		else $error("walk ran past the last location");
	chk_inval_skip: assert property ( // [R06]
		state == S_DEC && typ == `FCL_T_INVAL && !at_end
			|=> state == S_RD && loc == $past(loc) + 6'h1 && !word_we)
		else $error("invalidated location was not skipped");
	chk_unknown_skip: assert property ( // [R05] [R10]
		state == S_DEC && typ > `FCL_T_PHY && typ < `FCL_T_INVAL && !at_end
			|=> loc == $past(loc) + 6'h1 && !word_we && !phy_we)
		else $error("reserved type was not skipped");
	chk_word_load: assert property ( // [R20]
		state == S_DEC && typ == `FCL_T_WORD && hit
			|=> word_we && word_addr == $past(mem_rdata[`FCL_WADDR]))
		else $error("matching word entry was not loaded");
	chk_rtype_gate: assert property ( // [R11]
		state == S_DEC && mem_rdata[`FCL_RTYPE] == `FCL_RT_RSV
			|=> !word_we && !phy_we ##2 !csr_we)
		else $error("reserved reset type caused a load");
	chk_id_quiet: assert property ( // [R03]
		state == S_DEC && loc >= `FCL_FIRST_ID_LOC |=> !word_we && !phy_we)
		else $error("identity location caused a load");
	chk_csr_span: assert property ( // [R04]
		state == S_DEC && typ == `FCL_T_CSR && hit && !at_end
			&& loc + 6'h1 < `FCL_FIRST_ID_LOC
			|=> state == S_RD2 ##1 state == S_CSR ##1 csr_we)
		else $error("CSR entry did not load after two locations");
	chk_lock_gate: assert property ( // [R15]
		wr && paddr == `FCL_A_PDATA && fuse_lockout
			|=> !prog_pend && refused)
		else $error("programming accepted while locked");
	chk_no_rewrite: assert property ( // [R02]
		state == S_PWR && !prog_inval && mem_rdata != '0 |-> !mem_we)
		else $error("programmed location rewritten");
endmodule

/* File: fcl_load_sink.sv */
// Recorder that stands for the internal configuration structures.
`timescale 1ns/1ps
module fcl_load_sink (
	input wire logic pclk,
	input wire logic clr,
	input wire logic word_we,
	input wire logic csr_we,
	input wire logic phy_we,
	output logic [7:0] n_word,
	output logic [7:0] n_csr,
	output logic [7:0] n_phy
);
	// Counts every one-cycle load pulse of the current walk.
	always_ff @(posedge pclk)
	begin
		if (clr)
		begin
			n_word <= 8'h00;
			n_csr <= 8'h00;
			n_phy <= 8'h00;
		end
		else
		begin
			n_word <= n_word + 8'(word_we);
			n_csr <= n_csr + 8'(csr_we);
			n_phy <= n_phy + 8'(phy_we);
		end
	end
endmodule

/* File: fuse_config_autoload_parser_test.sv */
// Self-checking bench of the fuse configuration loader.
`timescale 1ns/1ps
`include "fcl_regs.svh"
`define CHK(a, b) \
	begin \
		total_checks++; \
		if ((a) !== (b)) \
		begin \
			n_mismatch++; \
			$display("CHECK FAILED t=%0t got %h exp %h", $time, a, b); \
		end \
	end
module fuse_config_autoload_parser_test;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, rd, csr_data;
	logic [31:0] img [64];
	logic pready, pslverr, err, clr = 1, security_strap = 1;
	logic pcie_reset_done = 0, sw_reset_done = 0;
	logic word_we, csr_we, phy_we, global_parity_enable;
	logic phy_link_disconnect, fuse_lockout, walk_busy, walk_done;
	logic [6:0] word_addr;
	logic [15:0] word_data, csr_addr, phy_data;
	logic [4:0] phy_addr;
	logic [47:0] station_addr;
	logic [7:0] n_word, n_csr, n_phy;
	int n_mismatch = 0;
	int total_checks = 0;

	fcl_parser u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr, .security_strap,
		.pcie_reset_done, .sw_reset_done, .word_we, .word_addr,
		.word_data, .csr_we, .csr_addr, .csr_data, .phy_we, .phy_addr,
		.phy_data, .station_addr, .global_parity_enable,
		.phy_link_disconnect, .fuse_lockout, .walk_busy, .walk_done);
	fcl_load_sink u_sink (.pclk, .clr, .word_we, .csr_we, .phy_we,
		.n_word, .n_csr, .n_phy);

	always #2 pclk = ~pclk;

	function automatic logic [31:0] wrd(input logic [6:0] a,
		input logic [1:0] rt, input logic [15:0] d);
		return {d, a, 4'h0, rt, `FCL_T_WORD};
	endfunction

	task automatic give_verdict();
		$display("checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	task automatic apb(input logic wr, input logic [11:0] a,
		input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1)
			@(posedge pclk);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic walk_wait();
		int k;
		k = 0;
		repeat (3) @(posedge pclk);
		while (walk_busy !== 1'b0 && k < 2000)
		begin
			@(posedge pclk);
			k++;
		end
	endtask

	task automatic walk_chk(input logic [7:0] nw, nc, np,
		input logic [6:0] cnt);
		walk_wait();
		`CHK(walk_done, 1'b1)
		`CHK(n_word, nw)
		`CHK(n_csr, nc)
		`CHK(n_phy, np)
		apb(1'b0, `FCL_A_STATUS, 32'h0);
		`CHK(rd[`FCL_S_CNT], cnt)
		clr <= 1'b1;
		@(posedge pclk);
		clr <= 1'b0;
	endtask

	initial
	begin
		#200000;
		n_mismatch++;
		give_verdict();
	end

	initial
	begin
		foreach (img[i])
			img[i] = 32'h0;
		img[0] = wrd(7'h00, 2'h0, 16'h1111);
		img[1] = wrd(7'h01, 2'h3, 16'h2222);
		img[2] = 32'h5555_0007;
		img[3] = 32'h0000_00ff;
		img[4] = 32'h0000_0004;
		img[5] = wrd(7'h02, 2'h2, 16'h3333);
		img[6] = {16'h0020, 5'h10, 11'h01b};
		img[7] = 32'h1234_001a;
		img[8] = 32'hdead_beef;
		img[9] = wrd(7'h0a, 2'h3, 16'h8001);
		img[10] = 32'h0007_01ef;
		img[11] = 32'h0000_0006;
		img[13] = wrd(7'h02, 2'h3, 16'hffff);
		#1;
		for (int i = 0; i < 32; i++)
			u_dut.u_store.mem[i] = {img[2*i+1], img[2*i]};
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		clr <= 1'b0;
		walk_chk(4, 1, 1, 6);
		`CHK(station_addr, 48'h3333_2222_1111)
		`CHK(rd[`FCL_S_VER], 5'd3)
		`CHK(rd[`FCL_S_LOCK], 1'b1)
		`CHK(fuse_lockout, 1'b1)
		`CHK(phy_link_disconnect, 1'b1)
		`CHK(global_parity_enable, 1'b1)
		`CHK(csr_addr, 16'h1234)
		`CHK(csr_data, 32'hdead_beef)
		`CHK(phy_addr, 5'h10)
		`CHK(phy_data, 16'h0020)
		`CHK(word_addr, 7'h0a)
		`CHK(word_data, 16'h8001)
		apb(1'b0, `FCL_A_ID, 32'h0);
		`CHK(rd, `FCL_DEV_ID_DEF)
		apb(1'b0, 12'hff0, 32'h0);
		`CHK(err, 1'b1)
		`CHK(rd, 32'h0)
		apb(1'b1, `FCL_A_CTRL, 32'h1);
		walk_chk(2, 1, 1, 4);
		pcie_reset_done <= 1'b1;
		repeat (6) @(posedge pclk);
		pcie_reset_done <= 1'b0;
		walk_chk(3, 1, 1, 5);
		apb(1'b1, `FCL_A_PADDR, 32'd12);
		apb(1'b1, `FCL_A_PDATA, wrd(7'h00, 2'h3, 16'habcd));
		apb(1'b0, `FCL_A_STATUS, 32'h0);
		`CHK(rd[`FCL_S_REFUSED], 1'b1)
		apb(1'b1, `FCL_A_CTRL, 32'h2);
		apb(1'b0, `FCL_A_STATUS, 32'h0);
		`CHK(rd[`FCL_S_REFUSED], 1'b0)
		security_strap <= 1'b0;
		repeat (4) @(posedge pclk);
		`CHK(fuse_lockout, 1'b0)
		apb(1'b1, `FCL_A_PADDR, 32'd12);
		apb(1'b1, `FCL_A_PDATA, wrd(7'h00, 2'h3, 16'habcd));
		walk_wait();
		apb(1'b1, `FCL_A_PDATA, wrd(7'h01, 2'h3, 16'h0000));
		walk_wait();
		apb(1'b0, `FCL_A_STATUS, 32'h0);
		`CHK(rd[`FCL_S_REFUSED], 1'b1)
		apb(1'b1, `FCL_A_CTRL, 32'h1);
		walk_chk(4, 1, 1, 6);
		`CHK(station_addr, 48'hffff_2222_abcd)
		apb(1'b1, `FCL_A_INVAL, 32'd13);
		walk_wait();
		apb(1'b1, `FCL_A_CTRL, 32'h1);
		walk_chk(3, 1, 1, 5);
		security_strap <= 1'b1;
		sw_reset_done <= 1'b1;
		repeat (6) @(posedge pclk);
		sw_reset_done <= 1'b0;
		walk_chk(3, 1, 1, 5);
		`CHK(fuse_lockout, 1'b1)
		for (int i = 7; i < 32; i++)
			u_dut.u_store.mem[i] = {2{32'h0000_0006}};
		u_dut.u_store.mem[30][`FCL_HI_HALF] = wrd(7'h01, 2'h3, 16'h5a5a);
		u_dut.u_store.mem[31] = {2{wrd(7'h01, 2'h3, 16'h5a5a)}};
		apb(1'b1, `FCL_A_CTRL, 32'h1);
		walk_chk(3, 1, 1, 5);
		`CHK(station_addr[31:16], 16'h2222)
		give_verdict();
	end
endmodule
